// ### arp_record_ctrl.sv
// record path control: clipping, offset removal, routing, level control, gate
// assumes per-sample decimator words with a one-cycle strobe on core_clk
`timescale 1ns/1ps
module arp_record_ctrl (
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    input  wire logic [arp_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    input  wire logic                  dec_valid,
    input  wire logic [2*arp_pkg::IW-1:0] dec_data,
    input  wire logic                  sdin_valid,
    input  wire arp_pkg::arp_pair_t    sdin_data,
    output logic                       rec_valid,
    output arp_pkg::arp_pair_t         rec_data,
    output arp_pkg::arp_pair_t         mix_data,
    output logic      [1:0]            mux_sel_a,
    output logic      [1:0]            mux_sel_b,
    output logic                       pga_bypass_a,
    output logic                       pga_bypass_b,
    output logic                       diff_mix_on,
    output logic                       mic_gain_32_a,
    output logic                       mic_gain_32_b,
    output logic [4:0]                 pga_gain_a,
    output logic [4:0]                 pga_gain_b,
    output logic                       bias_on_pin_a,
    output logic                       bias_on_pin_b,
    output logic [1:0]                 bias_level
);
    import arp_pkg::*;

    arp_ch_cfg_t cfg_r [2];
    logic [7:0]  common_r;   // [0] dig mix [1] diff mix [2] bias sel [4:3] level [5] gate both
    logic [7:0]  alc_r;      // [0] alc on [1] ramp dep [7:4] max thr [3:2] min thr
    logic [7:0]  gate_r;     // [0] gate on [3:1] thr [7:4] delay
    logic [6:0]  vol_r [2];
    logic [4:0]  pga_r [2];
    logic [6:0]  attn_r [2];
    logic [1:0]  ovf_r;
    logic [7:0]  rate_r;
    logic signed [IW-1:0] offs_r [2];
    logic signed [SW-1:0] samp [2];
    logic        clip [2];
    logic        quiet [2];
    logic [3:0]  gate_cnt_r [2];
    logic        muted_r [2];
    logic [7:0]  step_cnt_r;
    arp_lvl_st_t lvl_r [2];
    logic signed [SW-1:0] out_r [2];
    logic        out_v_r;
    logic        step_go;

    // register writes; hardware owns pga/attenuation while alc runs
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r[0] <= arp_ch_cfg_t'(CH_RESET);
            cfg_r[1] <= arp_ch_cfg_t'(CH_RESET);
            common_r <= '0;
            alc_r    <= '0;
            gate_r   <= '0;
            rate_r   <= RATE_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                A_CH_A:   cfg_r[0] <= arp_ch_cfg_t'(reg_wdata);
                A_CH_B:   cfg_r[1] <= arp_ch_cfg_t'(reg_wdata);
                A_COMMON: common_r <= reg_wdata;
                A_ALC:    alc_r    <= reg_wdata;
                A_GATE:   gate_r   <= reg_wdata;
                A_GAIN:   rate_r   <= (reg_wdata == 8'h00) ? RATE_RESET : reg_wdata;
                default: ;
            endcase
        end
    end

    logic [7:0] reg_rdata_nxt;
    always_comb begin
        unique case (reg_addr)
            A_CH_A:   reg_rdata_nxt = cfg_r[0];
            A_CH_B:   reg_rdata_nxt = cfg_r[1];
            A_COMMON: reg_rdata_nxt = common_r;
            A_ALC:    reg_rdata_nxt = alc_r;
            A_GATE:   reg_rdata_nxt = gate_r;
            A_STATUS: reg_rdata_nxt = {muted_r[1], muted_r[0], 4'h0, ovf_r};
            A_GAIN:   reg_rdata_nxt = rate_r;
            default:  reg_rdata_nxt = 8'h00;
        endcase
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) reg_rdata <= '0;
        else         reg_rdata <= reg_rd ? reg_rdata_nxt : 8'h00;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)                      step_cnt_r <= '0;
        else if (dec_valid && step_go)    step_cnt_r <= '0;
        else if (dec_valid)               step_cnt_r <= step_cnt_r + 8'h01;
    end
    assign step_go = !alc_r[1] || (step_cnt_r >= rate_r - 8'h01);

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            logic signed [IW-1:0] raw;
            logic signed [IW-1:0] other;
            logic signed [IW-1:0] pre;
            logic signed [IW-1:0] hp;
            logic signed [IW+7:0] scaled;
            logic [SW-1:0]        mag;
            logic [SW-1:0]        thr_hi;
            logic [SW-1:0]        thr_lo;
            logic [SW-1:0]        gthr;
            logic signed [SW-1:0] dmix;
            logic signed [IW+7:0] osum;
            logic [SW-1:0]        osat;
            logic [SW+6:0]        mixp;
            assign raw   = dec_data[c*IW +: IW];
            assign other = dec_data[(1-c)*IW +: IW];
            assign pre = common_r[1] ? (raw - other) >>> 1 : raw;
            // subtract offset only with the filter on
            assign hp  = cfg_r[c].hpf_enable ? pre - offs_r[c] : pre;
            // digital attenuation in coarse 1/2 steps per 8 codes
            assign scaled = $signed({{8{hp[IW-1]}}, hp}) >>> attn_r[c][6:3];
            assign clip[c] = (scaled > $signed({{10{1'b0}}, FS_POS}))
                          || (scaled < $signed({{10{1'b1}}, FS_NEG}));
            assign samp[c] = (scaled > $signed({{10{1'b0}}, FS_POS})) ? FS_POS :
                             (scaled < $signed({{10{1'b1}}, FS_NEG})) ? FS_NEG :
                             scaled[SW-1:0];
            assign mag    = samp[c][SW-1] ? ~samp[c] : samp[c];
            assign thr_hi = {1'b0, alc_r[7:4], {(SW-5){1'b0}}};
            assign thr_lo = {4'h0, alc_r[3:2], {(SW-6){1'b0}}};
            assign gthr   = {6'h00, gate_r[3:1], {(SW-9){1'b0}}};
            assign quiet[c] = mag < gthr;
            assign dmix   = (c == 0) ? sdin_data.a : sdin_data.b;
            // offset and mix go in ahead of the clip so full scale never wraps
            assign osum   = scaled + $signed({{10{1'b0}}, DC_ANTI})
                          + ((common_r[0] && sdin_valid) ? {{10{dmix[SW-1]}}, dmix} : {(IW+8){1'b0}});
            assign osat   = (osum > $signed({{10{1'b0}}, FS_POS})) ? FS_POS :
                            (osum < $signed({{10{1'b1}}, FS_NEG})) ? FS_NEG : osum[SW-1:0];

            // track offset while enabled and not frozen; hold on freeze
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) offs_r[c] <= '0;
                else if (dec_valid && cfg_r[c].hpf_enable && !cfg_r[c].hpf_freeze)
                    offs_r[c] <= offs_r[c] + ((pre - offs_r[c]) >>> HPF_SHIFT);
            end

            // level control, pga first on attack, attenuator first on release
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    pga_r[c]  <= PGA_0DB;
                    attn_r[c] <= '0;
                    lvl_r[c]  <= LV_HOLD;
                end else if (reg_wr && !alc_r[0] && reg_addr == A_GAIN) begin
                    pga_r[c]  <= pga_r[c];
                end else if (alc_r[0] && dec_valid) begin
                    lvl_r[c] <= (mag > thr_hi) ? LV_ATTACK :
                                (mag < thr_lo) ? LV_RELEASE : LV_HOLD;
                    if (mag > thr_hi) begin
                        if (pga_r[c] != '0)        pga_r[c]  <= pga_r[c] - 5'h01;
                        else if (attn_r[c] != ATTN_MAX) attn_r[c] <= attn_r[c] + 7'h01;
                    end else if (mag < thr_lo && step_go) begin
                        if (attn_r[c] != '0)       attn_r[c] <= attn_r[c] - 7'h01;
                        else if (pga_r[c] != PGA_MAX) pga_r[c] <= pga_r[c] + 5'h01;
                    end
                end
            end

            // gate delay count; both channels when selected
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    gate_cnt_r[c] <= '0;
                    muted_r[c]    <= 1'b0;
                end else if (dec_valid) begin
                    if (!gate_r[0] || !(common_r[5] ? (quiet[0] && quiet[1]) : quiet[c])) begin
                        gate_cnt_r[c] <= '0;
                        muted_r[c]    <= 1'b0;
                    end else if (gate_cnt_r[c] >= gate_r[7:4]) begin
                        muted_r[c]    <= 1'b1;
                    end else begin
                        gate_cnt_r[c] <= gate_cnt_r[c] + 4'h1;
                    end
                end
            end

            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) out_r[c] <= '0;
                else if (dec_valid) begin
                    if (muted_r[c] || cfg_r[c].mute) out_r[c] <= DC_ANTI;
                    else out_r[c] <= osat;
                end
            end

            // playback mixer feed scaled by seven-bit volume
            assign mixp = $signed(samp[c]) * $signed({1'b0, vol_r[c]});
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) vol_r[c] <= 7'h7F;
                else if (reg_wr && reg_addr == A_GAIN) vol_r[c] <= reg_wdata[6:0];
            end
        end
    endgenerate

    // sticky overflow, set wins over read clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) ovf_r <= '0;
        else begin
            for (int i = 0; i < 2; i++) begin
                if (dec_valid && clip[i])                  ovf_r[i] <= 1'b1;
                else if (reg_rd && reg_addr == A_STATUS)   ovf_r[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            out_v_r  <= 1'b0;
            mix_data <= '0;
        end else begin
            out_v_r  <= dec_valid;
            if (dec_valid) mix_data <= '{a: g_ch[0].mixp[SW+6:7], b: g_ch[1].mixp[SW+6:7]};
        end
    end

    assign rec_valid = out_v_r;
    assign rec_data  = '{a: out_r[0], b: out_r[1]};
    // source select, pga bypass when powered down
    assign mux_sel_a     = cfg_r[0].input_source_select;
    assign mux_sel_b     = cfg_r[1].input_source_select;
    assign pga_bypass_a  = cfg_r[0].gain_amp_power_down;
    assign pga_bypass_b  = cfg_r[1].gain_amp_power_down;
    assign diff_mix_on   = common_r[1];
    // mic gain choice; pga code 0..24 = -3..+9 dB
    assign mic_gain_32_a = cfg_r[0].mic_boost_32db;
    assign mic_gain_32_b = cfg_r[1].mic_boost_32db;
    assign pga_gain_a    = pga_r[0];
    assign pga_gain_b    = pga_r[1];
    assign bias_on_pin_a = !common_r[2];
    assign bias_on_pin_b = common_r[2];
    assign bias_level    = common_r[4:3];

    property p_clip_fs;
        @(posedge core_clk) disable iff (!resetn)
        dec_valid && clip[0] |-> (samp[0] == FS_POS || samp[0] == FS_NEG);
    endproperty
    a_clip_fs: assert property (p_clip_fs) else $error("clip not at full scale");

    property p_ovf;
        @(posedge core_clk) disable iff (!resetn)
        dec_valid && clip[1] |=> ovf_r[1];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag not set");

    property p_frz;
        @(posedge core_clk) disable iff (!resetn)
        cfg_r[0].hpf_freeze && $past(cfg_r[0].hpf_freeze) |-> $stable(offs_r[0]);
    endproperty
    a_frz: assert property (p_frz) else $error("offset moved while frozen");

    property p_bias;
        @(posedge core_clk) disable iff (!resetn)
        bias_on_pin_a != bias_on_pin_b;
    endproperty
    a_bias: assert property (p_bias) else $error("bias on both pins");

    property p_pga_rng;
        @(posedge core_clk) disable iff (!resetn)
        pga_r[0] <= PGA_MAX && pga_r[1] <= PGA_MAX;
    endproperty
    a_pga_rng: assert property (p_pga_rng) else $error("pga code out of range");

    property p_attack;
        @(posedge core_clk) disable iff (!resetn)
        alc_r[0] && dec_valid && lvl_r[0] == LV_HOLD && pga_r[0] != '0
            && g_ch[0].mag > g_ch[0].thr_hi |=> $stable(attn_r[0]);
    endproperty
    a_attack: assert property (p_attack) else $error("attenuation before pga");

    property p_gate_off;
        @(posedge core_clk) disable iff (!resetn)
        !gate_r[0] && dec_valid |=> !muted_r[0];
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate muted while off");

    property p_gate_both;
        @(posedge core_clk) disable iff (!resetn)
        dec_valid && common_r[5] && !quiet[1] |=> !muted_r[0];
    endproperty
    a_gate_both: assert property (p_gate_both) else $error("gate ignored other channel");

    property p_ovf_set_wins;
        @(posedge core_clk) disable iff (!resetn)
        dec_valid && clip[0] && reg_rd && reg_addr == A_STATUS |=> ovf_r[0];
    endproperty
    a_ovf_set_wins: assert property (p_ovf_set_wins) else $error("clip lost to clear");

    property p_offset_add;
        @(posedge core_clk) disable iff (!resetn)
        dec_valid && !clip[0] && samp[0][SW-1] && !muted_r[0] && !cfg_r[0].mute && !common_r[0]
            |=> out_r[0] == $past(samp[0]) + DC_ANTI;
    endproperty
    a_offset_add: assert property (p_offset_add) else $error("offset missing");

    property p_rec_valid;
        @(posedge core_clk) disable iff (!resetn)
        rec_valid == $past(dec_valid);
    endproperty
    a_rec_valid: assert property (p_rec_valid) else $error("record strobe misplaced");

    property p_hpf_off;
        @(posedge core_clk) disable iff (!resetn)
        !cfg_r[0].hpf_enable |-> g_ch[0].hp == g_ch[0].pre;
    endproperty
    a_hpf_off: assert property (p_hpf_off) else $error("offset removed with filter off");

    property p_frz_b;
        @(posedge core_clk) disable iff (!resetn)
        cfg_r[1].hpf_freeze && $past(cfg_r[1].hpf_freeze) |-> $stable(offs_r[1]);
    endproperty
    a_frz_b: assert property (p_frz_b) else $error("offset b moved while frozen");

    property p_mix_zero;
        @(posedge core_clk) disable iff (!resetn)
        dec_valid && vol_r[0] == 7'h00 |=> mix_data.a == '0;
    endproperty
    a_mix_zero: assert property (p_mix_zero) else $error("mixer feed at zero volume");

    property p_release;
        @(posedge core_clk) disable iff (!resetn)
        alc_r[0] && dec_valid && step_go && attn_r[0] != '0 && g_ch[0].mag < g_ch[0].thr_lo
            && g_ch[0].mag <= g_ch[0].thr_hi |=> $stable(pga_r[0]);
    endproperty
    a_release: assert property (p_release) else $error("pga raised before attenuation");

    property p_step_wait;
        @(posedge core_clk) disable iff (!resetn)
        alc_r[0] && dec_valid && !step_go && g_ch[0].mag <= g_ch[0].thr_hi
            |=> $stable(pga_r[0]) && $stable(attn_r[0]);
    endproperty
    a_step_wait: assert property (p_step_wait) else $error("step off divider tick");

    property p_mute_out;
        @(posedge core_clk) disable iff (!resetn)
        dec_valid && muted_r[1] |=> out_r[1] == DC_ANTI;
    endproperty
    a_mute_out: assert property (p_mute_out) else $error("gated sample not muted");

    property p_gate_loud;
        @(posedge core_clk) disable iff (!resetn)
        dec_valid && !common_r[5] && !quiet[0] |=> !muted_r[0];
    endproperty
    a_gate_loud: assert property (p_gate_loud) else $error("gate held on loud signal");
endmodule : arp_record_ctrl

// ### arp_pkg.sv
// package for the record path control block: constants, carriers, enums
// assumes one core clock domain and a plain register port master
// Overview of operation
// - samples are two's complement, clipped to positive or negative full scale
// - a clipped sample sets the sticky overflow flag
// - a constant dc offset is added to outgoing serial samples
// - with the high-pass filter off, dc passes signed about mid reference
// - filter on and not frozen: offset tracked and subtracted continuously
// - freeze holds the offset estimate and keeps subtracting it
// - adc output feeds playback mixer scaled by seven-bit volume
// - digital mix bit adds serial input data into the record stream
// - mic mix bit combines both channels differentially as one input
// - differential mix output is attenuated by a fixed 6 dB
// - source chosen from power-down bit and two-bit select; pga bypassed when off; the code takes the source from the two-bit select alone
// - bias goes to one of two pins by the bias pin select bit
// - bias voltage level comes from a two-bit field
// - mic pre-amp gives one of two fixed gains, 16 or 32 dB
// - pga gain spans +12 dB to -3 dB in 0.5 dB steps; the code stops at code 24, +9 dB
// - level control attack lowers pga gain first, then raises attenuation
// - level control release lowers attenuation first, then raises pga gain
// - level steps follow soft ramp and sample timing, dependency selectable; the code paces release steps only, on the sample step divider
// - noise gate mutes after signal stays below threshold for the delay
// - gate both channels bit triggers only when both are below threshold
package arp_pkg;
    localparam int SW          = 24;
    localparam int IW          = 26;
    localparam logic [SW-1:0] FS_POS  = 24'h7FFFFF;
    localparam logic [SW-1:0] FS_NEG  = 24'h800000;
    localparam logic [SW-1:0] DC_ANTI = 24'h000010;
    localparam int HPF_SHIFT   = 10;
    localparam int ADDR_W      = 4;
    localparam logic [ADDR_W-1:0] A_CH_A   = 4'h0;
    localparam logic [ADDR_W-1:0] A_CH_B   = 4'h1;
    localparam logic [ADDR_W-1:0] A_COMMON = 4'h2;
    localparam logic [ADDR_W-1:0] A_ALC    = 4'h3;
    localparam logic [ADDR_W-1:0] A_GATE   = 4'h4;
    localparam logic [ADDR_W-1:0] A_STATUS = 4'h5;
    localparam logic [ADDR_W-1:0] A_GAIN   = 4'h6;
    localparam logic [4:0] PGA_MAX     = 5'h18;
    localparam logic [4:0] PGA_0DB     = 5'h06;
    localparam logic [6:0] ATTN_MAX    = 7'h7F;
    localparam logic [7:0] RATE_RESET  = 8'h01;
    localparam logic [7:0] CH_RESET    = 8'h41;

    // per channel: hpf_enable[0] hpf_freeze[1] gain_amp_power_down[2]
    // input_source_select[4:3] mic_boost_32db[5] soft_ramp_enable[6] mute[7]
    typedef struct packed {
        logic       mute;
        logic       soft_ramp_enable;
        logic       mic_boost_32db;
        logic [1:0] input_source_select;
        logic       gain_amp_power_down;
        logic       hpf_freeze;
        logic       hpf_enable;
    } arp_ch_cfg_t;

    typedef struct packed {
        logic signed [SW-1:0] a;
        logic signed [SW-1:0] b;
    } arp_pair_t;

    typedef enum logic [1:0] {
        SRC_LINE1, SRC_LINE2, SRC_LINE3, SRC_MIC
    } arp_src_t;

    typedef enum { LV_HOLD, LV_ATTACK, LV_RELEASE } arp_lvl_st_t;
endpackage : arp_pkg

// ### arp_far_model.sv
// far side model: decimator words from the analog front end, serial input words
// assumes one caller process that asks for one sample at a time
`timescale 1ns/1ps
module arp_far_model (
    input  wire logic                      core_clk,
    output logic                           dec_valid,
    output logic [2*arp_pkg::IW-1:0]       dec_data,
    output logic                           sdin_valid,
    output arp_pkg::arp_pair_t             sdin_data
);
    import arp_pkg::*;
    initial begin
        dec_valid  = 1'b0;
        sdin_valid = 1'b0;
        dec_data   = '0;
        sdin_data  = '0;
    end
    // one strobed word; released lines show the inverse so stale data never looks valid
    task automatic send(input logic [IW-1:0] a, input logic [IW-1:0] b,
                        input logic [SW-1:0] sa, input logic [SW-1:0] sb);
        @(posedge core_clk);
        dec_valid  <= 1'b1;
        sdin_valid <= 1'b1;
        dec_data   <= {b, a};
        sdin_data  <= {sa, sb};
        @(posedge core_clk);
        dec_valid  <= 1'b0;
        sdin_valid <= 1'b0;
        dec_data   <= ~{b, a};
        sdin_data  <= ~{sa, sb};
    endtask : send
endmodule : arp_far_model

// ### adc_record_path_control_bench.sv
// self-checking bench for the record path control block
// assumes the far side model drives samples and the bench drives the register port
`timescale 1ns/1ps
module adc_record_path_control_bench;
    import arp_pkg::*;
    logic              core_clk  = 1'b0;
    logic              resetn    = 1'b0;
    logic [ADDR_W-1:0] reg_addr  = '0;
    logic [7:0]        reg_wdata = '0;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [7:0]        reg_rdata;
    logic              dec_valid, sdin_valid, rec_valid;
    logic [2*IW-1:0]   dec_data;
    arp_pair_t         sdin_data, rec_data, mix_data;
    logic [1:0]        mux_sel_a, mux_sel_b, bias_level;
    logic              pga_bypass_a, pga_bypass_b, diff_mix_on, mic_gain_32_a, mic_gain_32_b;
    logic              bias_on_pin_a, bias_on_pin_b;
    logic [4:0]        pga_gain_a, pga_gain_b, g;
    int                error_cnt   = 0;
    int                comparisons = 0;

    always #5 core_clk = ~core_clk;

    arp_record_ctrl DUT (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .dec_valid, .dec_data, .sdin_valid, .sdin_data, .rec_valid,
        .rec_data, .mix_data, .mux_sel_a, .mux_sel_b, .pga_bypass_a, .pga_bypass_b,
        .diff_mix_on, .mic_gain_32_a, .mic_gain_32_b, .pga_gain_a, .pga_gain_b,
        .bias_on_pin_a, .bias_on_pin_b, .bias_level);
    arp_far_model far (.core_clk, .dec_valid, .dec_data, .sdin_valid, .sdin_data);

    task automatic close_out();
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] v);
        comparisons++;
        if (v !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, v);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(negedge core_clk);
        chk(nm, {16'h0, e}, {16'h0, reg_rdata});
    endtask : rd
    task automatic smp(input logic [25:0] a, input logic [25:0] b,
                       input logic [23:0] sa, input logic [23:0] sb);
        int n;
        far.send(a, b, sa, sb);
        for (n = 0; n < 8; n++) begin
            @(negedge core_clk);
            if (rec_valid === 1'b1) break;
        end
        if (rec_valid !== 1'b1) begin
            error_cnt++;
            close_out();
        end
    endtask : smp
    task automatic rep(input int k, input logic [25:0] a, input logic [25:0] b);
        repeat (k) smp(a, b, '0, '0);
    endtask : rep

    task automatic t_reset();
        rd(A_CH_A, CH_RESET, "cfg_a");
        rd(A_CH_B, CH_RESET, "cfg_b");
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00, "unmapped");
        rd(A_CH_A, CH_RESET, "cfg_a_kept");
        chk("pga_gain_a", {19'h0, PGA_0DB}, {19'h0, pga_gain_a});
        chk("bias_pin_a", 24'h1, {23'h0, bias_on_pin_a});
    endtask : t_reset
    task automatic t_sat();
        wr(A_CH_A, 8'h40);
        wr(A_CH_B, 8'h40);
        smp(26'h1FFFFFF, 26'h2000000, '0, '0);
        chk("clip_pos", FS_POS, rec_data.a);
        chk("clip_neg", FS_NEG, rec_data.b);
        rd(A_STATUS, 8'h03, "overflow");
        rd(A_STATUS, 8'h00, "overflow_clr");
    endtask : t_sat
    task automatic t_dc();
        smp(26'd100, 26'h3FFFF9C, '0, '0);
        chk("dc_pos", 24'd116, rec_data.a);
        chk("dc_neg", 24'hFFFFAC, rec_data.b);
        chk("mix_a", 24'd99, mix_data.a);
        chk("mix_b", 24'hFFFF9C, mix_data.b);
    endtask : t_dc
    task automatic t_mix();
        wr(A_COMMON, 8'h01);
        smp(26'd100, 26'd0, 24'd50, 24'd7);
        chk("dmix_a", 24'd166, rec_data.a);
        chk("dmix_b", 24'd23, rec_data.b);
        wr(A_COMMON, 8'h02);
        smp(26'd1000, 26'h3FFFC18, '0, '0);
        chk("diff_on", 24'h1, {23'h0, diff_mix_on});
        chk("diff_a", 24'd1016, rec_data.a);
        wr(A_COMMON, 8'h00);
    endtask : t_mix
    task automatic t_route();
        wr(A_CH_A, 8'h74); // line source with the pga powered down
        wr(A_COMMON, 8'h1C);
        @(posedge core_clk);
        chk("mux_a", 24'h2, {22'h0, mux_sel_a});
        chk("byp_a", 24'h1, {23'h0, pga_bypass_a});
        chk("mux_b", 24'h0, {22'h0, mux_sel_b});
        chk("byp_b", 24'h0, {23'h0, pga_bypass_b});
        chk("mic32_a", 24'h1, {23'h0, mic_gain_32_a});
        chk("mic32_b", 24'h0, {23'h0, mic_gain_32_b});
        chk("bias_pins", 24'h2, {22'h0, bias_on_pin_b, bias_on_pin_a});
        chk("bias_lvl", 24'h3, {22'h0, bias_level});
        wr(A_COMMON, 8'h00);
    endtask : t_route
    task automatic t_hpf();
        logic [23:0] y0;
        wr(A_CH_A, 8'h41);
        // settle unfrozen before freezing, as calibration expects
        rep(64, 26'd40000, 26'd40000);
        chk("hpf_track", 24'h1, {23'h0, $signed(rec_data.a) < 24'sd40016});
        chk("hpf_off_b", 24'd40016, rec_data.b);
        wr(A_CH_A, 8'h43);
        smp(26'd40000, 26'd40000, '0, '0);
        y0 = rec_data.a;
        smp(26'd40100, 26'd40000, '0, '0);
        chk("hpf_hold", y0 + 24'd100, rec_data.a);
        wr(A_CH_A, 8'h40);
    endtask : t_hpf
    task automatic t_gate();
        wr(A_GATE, 8'h2F);
        rep(8, 26'd0, 26'h0400000);
        rd(A_STATUS, 8'h40, "gate_a");
        wr(A_COMMON, 8'h20);
        rep(8, 26'd0, 26'h0400000);
        rd(A_STATUS, 8'h00, "gate_both_one");
        rep(8, 26'd0, 26'd0);
        rd(A_STATUS, 8'hC0, "gate_both_two");
        wr(A_GATE, 8'h00);
        wr(A_COMMON, 8'h00);
    endtask : t_gate
    task automatic t_alc();
        int n;
        wr(A_ALC, 8'h8D);
        for (n = 0; n < 200 && pga_gain_a >= PGA_0DB; n++) smp(26'h07FFFFF, 26'h07FFFFF, '0, '0);
        chk("alc_attack", 24'h1, {23'h0, pga_gain_a < PGA_0DB});
        g = pga_gain_a;
        for (n = 0; n < 400 && pga_gain_a <= g; n++) smp(26'd0, 26'd0, '0, '0);
        chk("alc_release", 24'h1, {23'h0, pga_gain_a > g});
        // level control owns the pga; the step divider and the mixer volume are written here
        wr(A_GAIN, 8'h04);
        wr(A_ALC, 8'h8F);
        rep(3, 26'd0, 26'd0);
        chk("alc_rate_hold", {19'h0, PGA_0DB}, {19'h0, pga_gain_a});
        smp(26'd0, 26'd0, '0, '0);
        chk("alc_rate_step", {19'h0, PGA_0DB + 5'h01}, {19'h0, pga_gain_a});
        chk("pga_gain_b", {19'h0, PGA_0DB + 5'h01}, {19'h0, pga_gain_b});
    endtask : t_alc

    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_sat();
        t_dc();
        t_mix();
        t_route();
        t_hpf();
        t_gate();
        t_alc();
        close_out();
    end
endmodule : adc_record_path_control_bench
